// ===== logic/anps_pkg.sv
// Holds offsets, field positions and reset values of the partner status registers.
// Assumes a single management clock and same-clock negotiation logic.
package anps_pkg;

	localparam int          ANPS_ADDR_W      = 5;
	localparam int          ANPS_DATA_W      = 16;
	localparam int          ANPS_AUX_W       = 11;

	localparam logic [4:0]  ANPS_OFS_PARTNER = 5'h05;
	localparam logic [4:0]  ANPS_OFS_EXPAND  = 5'h06;

	// partner base page fields
	localparam int          ANPS_P_NP        = 15;
	localparam int          ANPS_P_ACK       = 14;
	localparam int          ANPS_P_RF        = 13;
	localparam int          ANPS_P_T4        = 9;
	localparam int          ANPS_P_ABIL_HI   = 8;
	localparam int          ANPS_P_ABIL_LO   = 5;
	localparam int          ANPS_P_SEL_HI    = 4;
	localparam int          ANPS_P_SEL_LO    = 0;
	localparam int          ANPS_P_SELCW_HI  = 3;

	// bits 12:9 forced to zero on read
	localparam logic [15:0] ANPS_P_RD_MASK   = 16'hE1FF;
	localparam logic [15:0] ANPS_P_RST       = 16'h0000;
	localparam logic [4:0]  ANPS_SEL_8023    = 5'h01;
	localparam logic [4:0]  ANPS_SEL_8029    = 5'h02;

	// expansion register fields
	localparam int          ANPS_E_RSVD_HI   = 15;
	localparam int          ANPS_E_RSVD_LO   = 5;
	localparam int          ANPS_E_PDF       = 4;
	localparam int          ANPS_E_LPNPA     = 3;
	localparam int          ANPS_E_NPA       = 2;
	localparam int          ANPS_E_PR        = 1;
	localparam int          ANPS_E_LPANA     = 0;

	localparam logic        ANPS_NPA_RST     = 1'b1;
	localparam logic        ANPS_FLAG_RST    = 1'b0;
	localparam logic [10:0] ANPS_AUX_RST     = 11'h000;
	localparam logic [15:0] ANPS_RD_RST      = 16'h0000;

endpackage : anps_pkg

// ===== logic/anps_latch_high.sv
// One latch-high status bit with clear on register read.
// Assumes setCond and clrRead come from logic on clk_sys.
`timescale 1ns/1ps
`default_nettype none
module anps_latch_high
	import anps_pkg::*;
(
	input  wire logic clk_sys,
	input  wire logic sys_rst,
	input  wire logic setCond,
	input  wire logic clrRead,
	output logic      flag
);

	logic flag_reg;

	// set wins over the read clear, so an event in the read cycle is kept
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			flag_reg <= ANPS_FLAG_RST;
		end else begin
			flag_reg <= setCond | (flag_reg & ~clrRead);
		end
	end

	assign flag = flag_reg;

endmodule : anps_latch_high
`default_nettype wire

// ===== logic/anps_word_capture.sv
// Stores the base page code word received from the link partner.
// Assumes wordValid is a one-cycle strobe from the negotiation logic.
`timescale 1ns/1ps
`default_nettype none
module anps_word_capture
	import anps_pkg::*;
(
	input  wire logic        clk_sys,
	input  wire logic        sys_rst,
	input  wire logic        wordValid,
	input  wire logic [15:0] wordIn,
	input  wire logic        selWrEn,
	input  wire logic [3:0]  selWrData,
	output logic      [15:0] wordOut,
	output logic             wordStored
);

	logic [15:0] word_reg;
	logic        stored_reg;

	// a received word wins over a management override in the same cycle
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			word_reg <= ANPS_P_RST;
		end else if (wordValid) begin
			word_reg <= wordIn & ANPS_P_RD_MASK;
		end else if (selWrEn) begin
			word_reg[ANPS_P_SELCW_HI:ANPS_P_SEL_LO] <= selWrData;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			stored_reg <= 1'b0;
		end else begin
			stored_reg <= wordValid;
		end
	end

	assign wordOut    = word_reg;
	assign wordStored = stored_reg;

endmodule : anps_word_capture
`default_nettype wire

// ===== logic/anps_partner_status_regs.sv
// Partner base page and negotiation expansion status registers.
// Assumes management strobes and negotiation events all arrive on clk_sys.
`timescale 1ns/1ps
`default_nettype none
module anps_partner_status_regs
	import anps_pkg::*;
(
	input  wire logic        clk_sys,
	input  wire logic        sys_rst,
	// management register port
	input  wire logic [4:0]  regAddr,
	input  wire logic        regRdEn,
	input  wire logic        regWrEn,
	input  wire logic [15:0] regWrData,
	output logic      [15:0] regRdData,
	output logic             regRdValid,
	input  wire logic        cmdOverride,
	// negotiation engine side
	input  wire logic        partnerWordValid,
	input  wire logic [15:0] partnerWord,
	input  wire logic        flpBurstValid,
	input  wire logic        parallelFault,
	input  wire logic        negRestart,
	// decoded status for the rest of the device
	output logic             partnerMorePages,
	output logic             partnerAck,
	output logic             partnerRemoteFault,
	output logic      [3:0]  partnerAbility,
	output logic             partnerSelectorOk,
	output logic             pageReceived,
	output logic             parallelDetectFault,
	output logic             partnerNextPageAble,
	output logic             partnerAnAble,
	output logic      [10:0] expansionAux
);

	logic [15:0] partnerWord_q;
	logic        wordStored;
	logic        rdPartner;
	logic        rdExpand;
	logic        wrPartner;
	logic        wrExpand;
	logic        cwWrPartner;
	logic        cwWrExpand;
	logic [15:0] partnerView;
	logic [15:0] expandView;
	logic [15:0] rdData_next;
	logic [15:0] rdData_reg;
	logic        rdValid_reg;
	logic        lpNpAble_reg;
	logic        lpAnAble_reg;
	logic        localNpAble_reg;
	logic [10:0] aux_reg;
	logic        prFlag;
	logic        pdfFlag;
	logic        selOk_reg;

	// address decode
	assign rdPartner   = regRdEn && (regAddr == ANPS_OFS_PARTNER);
	assign rdExpand    = regRdEn && (regAddr == ANPS_OFS_EXPAND);
	assign wrPartner   = regWrEn && (regAddr == ANPS_OFS_PARTNER);
	assign wrExpand    = regWrEn && (regAddr == ANPS_OFS_EXPAND);

	// override-write bits are isolated unless the command override is set
	assign cwWrPartner = wrPartner && cmdOverride;
	assign cwWrExpand  = wrExpand && cmdOverride;

	// software relies on the far side restoring reserved defaults

	anps_word_capture uCapture (
		.clk_sys    (clk_sys),
		.sys_rst    (sys_rst),
		.wordValid  (partnerWordValid),
		.wordIn     (partnerWord),
		.selWrEn    (cwWrPartner),
		.selWrData  (regWrData[ANPS_P_SELCW_HI:ANPS_P_SEL_LO]),
		.wordOut    (partnerWord_q),
		.wordStored (wordStored)
	);

	// page received: a new word was stored, cleared by reading expansion
	anps_latch_high uPageRx (
		.clk_sys (clk_sys),
		.sys_rst (sys_rst),
		.setCond (wordStored),
		.clrRead (rdExpand),
		.flag    (prFlag)
	);

	// parallel-detection fault latched until an expansion read after the condition ends
	anps_latch_high uParFault (
		.clk_sys (clk_sys),
		.sys_rst (sys_rst),
		.setCond (parallelFault),
		.clrRead (rdExpand),
		.flag    (pdfFlag)
	);

	// partner next-page-able stays until negotiation restarts
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			lpNpAble_reg <= ANPS_FLAG_RST;
		end else if (partnerWordValid && partnerWord[ANPS_P_NP]) begin
			lpNpAble_reg <= 1'b1;
		end else if (negRestart) begin
			lpNpAble_reg <= 1'b0;
		end
	end

	// partner negotiation-able set by the burst detector, held until negotiation restarts
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			lpAnAble_reg <= ANPS_FLAG_RST;
		end else if (flpBurstValid) begin
			lpAnAble_reg <= 1'b1;
		end else if (negRestart) begin
			lpAnAble_reg <= 1'b0;
		end
	end

	// local next-page support is fixed
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			localNpAble_reg <= ANPS_NPA_RST;
		end else begin
			localNpAble_reg <= ANPS_NPA_RST;
		end
	end

	// hidden auxiliary controls behind the reserved expansion bits;
	// they steer the device but never read back
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			aux_reg <= ANPS_AUX_RST;
		end else if (cwWrExpand) begin
			aux_reg <= regWrData[ANPS_E_RSVD_HI:ANPS_E_RSVD_LO];
		end
	end

	// selector check registered to keep the output glitch free
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			selOk_reg <= 1'b0;
		end else begin
			selOk_reg <= (partnerWord_q[ANPS_P_SEL_HI:ANPS_P_SEL_LO] == ANPS_SEL_8023);
		end
	end

	// read views
	always_comb begin
		partnerView = partnerWord_q & ANPS_P_RD_MASK;
		partnerView[ANPS_P_T4] = 1'b0;
	end

	always_comb begin
		expandView                = 16'h0000;
		expandView[ANPS_E_PDF]    = pdfFlag;
		expandView[ANPS_E_LPNPA]  = lpNpAble_reg;
		expandView[ANPS_E_NPA]    = localNpAble_reg;
		expandView[ANPS_E_PR]     = prFlag;
		expandView[ANPS_E_LPANA]  = lpAnAble_reg;
	end

	// unmapped addresses answer zero
	always_comb begin
		rdData_next = rdData_reg;
		if (rdPartner) begin
			rdData_next = partnerView;
		end else if (rdExpand) begin
			rdData_next = expandView;
		end else if (regRdEn) begin
			rdData_next = 16'h0000;
		end
	end

	// read data is the value seen in the cycle of the read strobe
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			rdData_reg <= ANPS_RD_RST;
		end else begin
			rdData_reg <= rdData_next;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			rdValid_reg <= 1'b0;
		end else begin
			rdValid_reg <= regRdEn;
		end
	end

	assign regRdData           = rdData_reg;
	assign regRdValid          = rdValid_reg;
	assign partnerMorePages    = partnerWord_q[ANPS_P_NP];
	assign partnerAck          = partnerWord_q[ANPS_P_ACK];
	assign partnerRemoteFault  = partnerWord_q[ANPS_P_RF];
	assign partnerAbility      = partnerWord_q[ANPS_P_ABIL_HI:ANPS_P_ABIL_LO];
	assign partnerSelectorOk   = selOk_reg;
	assign pageReceived        = prFlag;
	assign parallelDetectFault = pdfFlag;
	assign partnerNextPageAble = lpNpAble_reg;
	assign partnerAnAble       = lpAnAble_reg;
	assign expansionAux        = aux_reg;

	// validity of the partner word is judged by software

endmodule : anps_partner_status_regs
`default_nettype wire

// ===== tb/anps_chk_assertions.sv
// checker: port timing of the partner status registers
// assumes one clk_sys domain; bound into anps_partner_status_regs by the bind below
`timescale 1ns/1ps
`default_nettype none
module anps_chk (
	input wire logic clk_sys, sys_rst, regRdEn, partnerWordValid, flpBurstValid, parallelFault,
	input wire logic partnerMorePages, partnerAck, partnerRemoteFault, pageReceived,
	input wire logic parallelDetectFault, partnerNextPageAble, partnerAnAble,
	input wire logic [4:0] regAddr,
	input wire logic [15:0] regRdData, partnerWord,
	input wire logic [3:0] partnerAbility
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (sys_rst);
	word_top_a: assert property (partnerWordValid |=>
		{partnerMorePages, partnerAck, partnerRemoteFault} == $past(partnerWord[15:13]))
		else $error("top bits not loaded");
	word_ability_a: assert property (partnerWordValid |=>
		partnerAbility == $past(partnerWord[8:5])) else $error("ability not loaded");
	p_rsvd_a: assert property ($past(regRdEn && regAddr == 5'h05) |->
		regRdData[12:9] == 4'h0) else $error("partner reserved bits set");
	e_rsvd_a: assert property ($past(regRdEn && regAddr == 5'h06) |->
		regRdData[15:5] == 11'h000 && regRdData[2]) else $error("expansion view wrong");
	pr_set_a: assert property (partnerWordValid |=> ##1 pageReceived)
		else $error("page flag not set");
	pr_clear_a: assert property (regRdEn && regAddr == 5'h06 &&
		!$past(partnerWordValid) |=> !pageReceived) else $error("page flag not cleared");
	pdf_set_a: assert property (parallelFault |=> parallelDetectFault)
		else $error("fault flag not set");
	npa_set_a: assert property (partnerWordValid && partnerWord[15] |=>
		partnerNextPageAble) else $error("next page able not set");
	an_set_a: assert property (flpBurstValid |=> partnerAnAble)
		else $error("negotiation able not set");
endmodule : anps_chk
bind anps_partner_status_regs anps_chk anps_chk_i (.clk_sys, .sys_rst, .regRdEn,
	.partnerWordValid, .flpBurstValid, .parallelFault, .partnerMorePages, .partnerAck,
	.partnerRemoteFault, .pageReceived, .parallelDetectFault, .partnerNextPageAble,
	.partnerAnAble, .regAddr, .regRdData, .partnerWord, .partnerAbility);
`default_nettype wire

// ===== tb/anps_link_partner.sv
// remote partner and negotiation events toward the status registers
// tasks are called by the bench at clk_sys falling edges
`timescale 1ns/1ps
`default_nettype none
module anps_link_partner (
	input  wire logic        clk_sys,
	output logic             partnerWordValid,
	output logic      [15:0] partnerWord,
	output logic             flpBurstValid,
	output logic             parallelFault,
	output logic             negRestart
);
	initial begin
		{partnerWordValid, flpBurstValid, parallelFault, negRestart} = 4'h0;
		partnerWord = 16'hA5C3;
	end
	task automatic send(input logic [15:0] a, input logic [15:0] b, input logic two);
		partnerWordValid = 1'b1;
		partnerWord = a;
		@(negedge clk_sys);
		if (two) begin
			partnerWord = b;
			@(negedge clk_sys);
		end
		partnerWordValid = 1'b0;
		// idle word inverted so a stale value never looks valid
		partnerWord = ~partnerWord;
	endtask : send
	task automatic ev(input logic [2:0] m);
		{flpBurstValid, parallelFault, negRestart} = m;
		@(negedge clk_sys);
		{flpBurstValid, parallelFault, negRestart} = 3'h0;
	endtask : ev
	task automatic hold(input logic v);
		parallelFault = v;
	endtask : hold
endmodule : anps_link_partner
`default_nettype wire

// ===== tb/tb_top.sv
// self-checking bench for the partner status registers
// link partner model makes negotiation events; bench drives management
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic clk_sys, sys_rst, regRdEn, regWrEn, regRdValid, cmdOverride;
	logic partnerWordValid, flpBurstValid, parallelFault, negRestart, partnerMorePages;
	logic partnerAck, partnerRemoteFault, partnerSelectorOk, pageReceived;
	logic parallelDetectFault, partnerNextPageAble, partnerAnAble;
	logic [4:0]  regAddr;
	logic [15:0] regWrData, regRdData, partnerWord;
	logic [3:0]  partnerAbility;
	logic [10:0] expansionAux;
	int          mismatches = 0;
	int          cmp_count = 0;
	anps_partner_status_regs anps_partner_status_regs_i (.clk_sys, .sys_rst, .regAddr,
		.regRdEn, .regWrEn, .regWrData, .regRdData, .regRdValid, .cmdOverride,
		.partnerWordValid, .partnerWord, .flpBurstValid, .parallelFault, .negRestart,
		.partnerMorePages, .partnerAck, .partnerRemoteFault, .partnerAbility,
		.partnerSelectorOk, .pageReceived, .parallelDetectFault, .partnerNextPageAble,
		.partnerAnAble, .expansionAux);
	anps_link_partner anps_link_partner_i (.clk_sys, .partnerWordValid, .partnerWord,
		.flpBurstValid, .parallelFault, .negRestart);
	initial begin
		clk_sys = 1'b0;
		forever #10 clk_sys = ~clk_sys;
	end
	task automatic chk(input logic [15:0] s, input logic [15:0] e);
		cmp_count++;
		if (s !== e) begin
			mismatches++;
			$display("MISMATCH %0t got %h expected %h", $time, s, e);
		end
	endtask : chk
	task automatic end_of_test();
		$display("mismatches %0d compares %0d", mismatches, cmp_count);
		if (mismatches == 0 && cmp_count > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask : end_of_test
	task automatic rd(input logic [4:0] a, input logic [15:0] e);
		regAddr = a;
		regRdEn = 1'b1;
		@(negedge clk_sys);
		regRdEn = 1'b0;
		chk({15'h0, regRdValid}, 16'h0001);
		chk(regRdData, e);
		@(negedge clk_sys);
	endtask : rd
	task automatic wr(input logic [4:0] a, input logic [15:0] d);
		regAddr = a;
		regWrData = d;
		regWrEn = 1'b1;
		@(negedge clk_sys);
		regWrEn = 1'b0;
		@(negedge clk_sys);
	endtask : wr
	task automatic t_page();
		rd(5'h05, 16'h0000);
		rd(5'h06, 16'h0004);
		rd(5'h07, 16'h0000);
		anps_link_partner_i.send(16'hFFFF, 16'h0000, 1'b0);
		chk({9'h0, partnerMorePages, partnerAck, partnerRemoteFault, partnerAbility},
			16'h007F);
		@(negedge clk_sys);
		// page flag rises one cycle after the partner word outputs update
		chk({15'h0, pageReceived}, 16'h0001);
		rd(5'h05, 16'hE1FF);
		rd(5'h06, 16'h000E);
		rd(5'h06, 16'h000C);
		// both defined selector codes, only the first is accepted
		for (logic [4:0] s = 5'h01; s < 5'h03; s++) begin
			anps_link_partner_i.send({11'h001, s}, 16'h0000, 1'b0);
			@(negedge clk_sys);
			chk({14'h0, partnerAck, partnerSelectorOk}, {15'h0, s == 5'h01});
			rd(5'h05, {11'h001, s});
		end
		anps_link_partner_i.send(16'h01E1, 16'h0021, 1'b1);
		@(negedge clk_sys);
		rd(5'h05, 16'h0021);
		rd(5'h06, 16'h000E);
	endtask : t_page
	task automatic t_override();
		wr(5'h05, 16'h000F);
		rd(5'h05, 16'h0021);
		cmdOverride = 1'b1;
		wr(5'h05, 16'h002A);
		rd(5'h05, 16'h002A);
		wr(5'h06, 16'h0020);
		chk({5'h0, expansionAux}, 16'h0001);
		rd(5'h06, 16'h000C);
		wr(5'h06, 16'h0000);
		cmdOverride = 1'b0;
		wr(5'h06, 16'hFFE0);
		chk({5'h0, expansionAux}, 16'h0000);
	endtask : t_override
	task automatic t_flags();
		anps_link_partner_i.ev(3'b010);
		rd(5'h06, 16'h001C);
		rd(5'h06, 16'h000C);
		anps_link_partner_i.hold(1'b1);
		@(negedge clk_sys);
		rd(5'h06, 16'h001C);
		rd(5'h06, 16'h001C);
		anps_link_partner_i.hold(1'b0);
		rd(5'h06, 16'h001C);
		rd(5'h06, 16'h000C);
		anps_link_partner_i.ev(3'b100);
		rd(5'h06, 16'h000D);
		anps_link_partner_i.ev(3'b001);
		rd(5'h06, 16'h0004);
	endtask : t_flags
	// mid-run reset must drop the stored word and the sticky partner flags
	task automatic t_reset();
		anps_link_partner_i.send(16'h8021, 16'h0000, 1'b0);
		sys_rst = 1'b1;
		repeat (2) @(negedge clk_sys);
		sys_rst = 1'b0;
		rd(5'h05, 16'h0000);
		rd(5'h06, 16'h0004);
	endtask : t_reset
	initial begin
		{sys_rst, regRdEn, regWrEn, cmdOverride} = 4'h8;
		regAddr = 5'h00;
		regWrData = 16'h0000;
		repeat (6) @(negedge clk_sys);
		sys_rst = 1'b0;
		t_page();
		t_override();
		t_flags();
		t_reset();
		end_of_test();
	end
	// run needs about 80 cycles
	initial begin
		repeat (1000) @(posedge clk_sys);
		mismatches++;
		end_of_test();
	end
endmodule : tb_top
`default_nettype wire
